// file: logic/mmd_memory_map_decoder.sv
// Design decision made here: the APB register port.
`timescale 1ns/10ps
module mmd_memory_map_decoder (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  // apb slave
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // core access port
  input  wire mmd_pkg::mmd_req_type req,
  output logic                      reqReady,
  input  wire logic [7:0]           port4Gpio,
  input  wire logic [7:0]           port1Gpio,
  output mmd_pkg::mmd_ext_type      ext,
  output mmd_pkg::mmd_int_type      intMem
);
  import mmd_pkg::*;

  // whole module state
  typedef struct packed {
    // register contents
    logic [7:0]    p4fn;    // port4_pin_function
    logic [7:0]    mmap;    // memory_map_control
    logic [7:0]    actl;    // address_ctrl
    // access bookkeeping
    logic          refused; // sticky refused-access flag
    mmd_tgt_type   lastTgt; // target of last access
    mmd_state_type st;      // external access sequencer
    // registered outputs
    logic [31:0]   rdata;   // apb read data
    mmd_ext_type   ext;     // external pins
    mmd_int_type   intMem;  // on-chip memory selects
  } mmd_all_type;

  mmd_all_type state_reg;   // registered state
  mmd_all_type state_next;  // next state

  // configuration view
  logic [1:0]  mapSel;      // internal_ram_map_sel
  logic        sharedMode;  // SRAM as shared program/data
  logic        stackOn;     // effective stack_extend
  logic        demuxMode;   // demultiplexed low address
  logic [22:0] sramBase;    // data-move SRAM base

  // window decode of the pending request
  logic        sramHit;     // lands in on-chip SRAM
  logic        canHit;      // lands in message RAM
  logic        reserved;    // data move into stack area
  logic        isData;      // data move, read or write
  logic [22:0] offSram;     // offset into SRAM window
  logic [22:0] offCan;      // offset into message RAM window

  // chip-select decode
  logic [4:0]  csShift;     // region width in address bits
  logic [22:0] csIndex;     // region number
  logic [3:0]  selEn;       // program selects enabled on pins
  logic [3:0]  csHot;       // one-hot select for this address

  // register bus decode
  logic        apbSetup;    // setup phase
  logic        apbAccess;   // access phase
  logic [7:0]  apbIdx;      // register index
  logic        apbMapped;   // index names a register

  // static configuration view
  always_comb begin
    // selector bits side by side
    mapSel     = {state_reg.mmap[MMD_MAP_HI_BIT],
                  state_reg.mmap[MMD_MAP_LO_BIT]};
    sharedMode = (mapSel == 2'h3);
    stackOn    = state_reg.actl[MMD_STACK_BIT] && !sharedMode;
    demuxMode  = state_reg.actl[MMD_DEMUX_BIT];
    // data window base; 10 and 11 share the high base
    case (mapSel)
      2'h0:    sramBase = MMD_SRAM_F000;
      2'h1:    sramBase = MMD_SRAM_LOW;
      default: sramBase = MMD_SRAM_HIGH; // 10 and shared 11
    endcase
  end

  // address decode of the pending request
  always_comb begin
    // data moves are both external_data_move kinds
    isData  = (req.kind == MMD_DRD) || (req.kind == MMD_DWR);
    // window offsets; an address below a base wraps high and misses
    offSram = req.addr - sramBase;
    offCan  = req.addr - (state_reg.mmap[MMD_CAN_BIT] ? MMD_CAN_HIGH
                                                       : MMD_CAN_LOW);
    // SRAM: data moves in data modes, any space in shared mode
    sramHit = (offSram < MMD_SRAM_SIZE) && (isData || sharedMode);
    // stack accesses always land on-chip when extension is on
    if (req.stack && stackOn) begin
      sramHit = 1'b1;
    end
    // data moves may not touch the stack area
    reserved = stackOn && isData && !req.stack &&
               sramHit && (offSram < MMD_STACK_SIZE);
    // message RAM is a data-move target only
    canHit  = isData && (offCan < MMD_CAN_SIZE);

    // chip-select region size from the upper-address field
    case (state_reg.p4fn[5:3])
      3'h4:    csShift = MMD_CS_SH_100;
      3'h5:    csShift = MMD_CS_SH_101;
      3'h6:    csShift = MMD_CS_SH_110;
      3'h7:    csShift = MMD_CS_SH_111;
      default: csShift = MMD_CS_SH_000;
    endcase
    // region number; high regions fall outside all four
    csIndex = req.addr >> csShift;
    // selects present on pins by the lower field
    case (state_reg.p4fn[2:0])
      3'h4:    selEn = 4'h1;
      3'h5:    selEn = 4'h3;
      3'h6:    selEn = 4'h7;
      3'h7:    selEn = 4'hf;
      default: selEn = 4'h0;
    endcase

    // one-hot select; region four and above gets none
    csHot = 4'h0;
    if (csIndex < 23'd4) begin
      csHot[csIndex[1:0]] = 1'b1;
    end
  end

  // apb phase decode; index is byte address over four
  always_comb begin
    apbSetup  = psel && !penable;
    apbAccess = psel && penable;
    apbIdx    = paddr[9:2];
    apbMapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                ((apbIdx == MMD_IDX_P4FN) || (apbIdx == MMD_IDX_MMAP) ||
                 (apbIdx == MMD_IDX_ACTL) || (apbIdx == MMD_IDX_STAT));
    // no wait states; errors only in the access phase
    pready    = 1'b1;
    pslverr   = apbAccess && !apbMapped;
    prdata    = state_reg.rdata;
    // core handshake and pins straight from flops
    reqReady  = (state_reg.st == MMD_ST_IDLE);
    ext       = state_reg.ext;
    intMem    = state_reg.intMem;
  end

  // next state
  always_comb begin
    state_next = state_reg;
    // register read data captured in the setup cycle
    if (apbSetup) begin
      state_next.rdata = 32'h0;
      // unmapped reads return zero
      if (apbMapped) begin
        case (apbIdx)
          MMD_IDX_P4FN: state_next.rdata = {24'h0, state_reg.p4fn};
          MMD_IDX_MMAP: state_next.rdata = {24'h0, state_reg.mmap};
          // stack bit reads back its effective value
          MMD_IDX_ACTL: state_next.rdata = {24'h0, state_reg.actl[7:3],
                                            stackOn, state_reg.actl[1:0]};
          // sticky flag over the last target code
          MMD_IDX_STAT: state_next.rdata = {24'h0, state_reg.refused,
                                            5'h0, state_reg.lastTgt};
          default:      state_next.rdata = 32'h0;
        endcase
      end
    end

    // register writes in the access cycle
    if (apbAccess && pwrite && apbMapped) begin
      case (apbIdx)
        // undefined bits of each register read zero (p4fn 7:6, mmap 4, actl 7:6, 4:3, 1:0)
        MMD_IDX_P4FN: state_next.p4fn = {2'h0, pwdata[5:0]};
        MMD_IDX_MMAP: state_next.mmap = {pwdata[7:5], 1'b0, pwdata[3:0]};
        MMD_IDX_ACTL: state_next.actl = {2'h0, pwdata[5], 2'h0,
                                         pwdata[2], 2'h0};
        MMD_IDX_STAT: begin
          if (pwdata[MMD_STAT_REFUSE]) begin
            state_next.refused = 1'b0; // write one to clear
          end
        end
        default: state_next.p4fn = state_reg.p4fn;
      endcase
    end
    // on-chip selects last one cycle
    state_next.intMem.sramSel = 1'b0;
    state_next.intMem.canSel  = 1'b0;
    state_next.intMem.sramWr  = 1'b0;
    state_next.intMem.canWr   = 1'b0;
    // pin functions follow the port field at all times
    for (int i = 0; i < 4; i++) begin
      // upper pins carry A16+i when the field reaches them
      state_next.ext.port4AddrEn[4 + i] =
        state_reg.p4fn[5] && (i <= int'(state_reg.p4fn[4:3]));
      state_next.ext.port4AddrEn[i] = selEn[i];
    end
    // demux mode claims port 1 for A7..A0
    state_next.ext.port1AddrEn = demuxMode;
    // port 0 shows an address only in a strobe cycle
    state_next.ext.port0AddrEn = 1'b0;

    // release strobes and selects; a taken access overrides below
    state_next.ext.loadN       = 1'b1;
    state_next.ext.storeN      = 1'b1;
    state_next.ext.fetchN      = 1'b1;
    state_next.ext.dataSelN    = 4'hf;
    state_next.ext.port0DataEn = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // lower pins: idle-high select, else gpio
      state_next.ext.port4Out[i] = selEn[i] ? 1'b1 : port4Gpio[i];
      // upper pins: hold the last address, else gpio
      state_next.ext.port4Out[4 + i] =
        state_next.ext.port4AddrEn[4 + i] ? state_reg.ext.port4Out[4 + i]
                                           : port4Gpio[4 + i];
    end
    // low address port is gpio in multiplexed mode
    if (!demuxMode) begin
      state_next.ext.port1Out = port1Gpio;
    end

    // one external strobe cycle, then back to idle
    case (state_reg.st)
      // idle: take at most one request per cycle
      MMD_ST_IDLE: begin
        // priority: refusal, SRAM, message RAM, external
        if (req.valid) begin
          if (reserved) begin
            // refused; set wins over a same-cycle clear
            state_next.refused = 1'b1;
            state_next.lastTgt = MMD_TGT_NONE;
          end else if (sramHit) begin
            // served on-chip, external strobes stay high
            state_next.intMem.sramSel  = 1'b1;
            state_next.intMem.sramWr   = (req.kind == MMD_DWR);
            state_next.intMem.sramAddr = req.stack && stackOn ?
                                         {2'h0, req.addr[9:0]}
                                         : offSram[11:0];
            state_next.lastTgt         = MMD_TGT_SRAM;
          end else if (canHit) begin
            state_next.intMem.canSel  = 1'b1;
            state_next.intMem.canWr   = (req.kind == MMD_DWR);
            state_next.intMem.canAddr = offCan[8:0];
            state_next.lastTgt        = MMD_TGT_CAN;
          end else begin
            // external access: address on pins and strobe in the same cycle
            state_next.lastTgt = MMD_TGT_EXT;
            state_next.st      = MMD_ST_STROBE;
            for (int i = 0; i < 4; i++) begin
              if (state_next.ext.port4AddrEn[4 + i]) begin
                state_next.ext.port4Out[4 + i] = req.addr[16 + i];
              end
            end
            // middle address byte always on port 2
            state_next.ext.port2Out = req.addr[15:8];
            // low byte on port 1, or multiplexed on port 0
            if (demuxMode) begin
              state_next.ext.port1Out = req.addr[7:0];
            end else begin
              state_next.ext.port0Addr   = req.addr[7:0];
              state_next.ext.port0AddrEn = 1'b1;
            end
            if (!isData) begin
              // program space: program select and fetch strobe
              for (int i = 0; i < 4; i++) begin
                if (selEn[i] && csHot[i]) begin
                  state_next.ext.port4Out[i] = 1'b0;
                end
              end
              state_next.ext.fetchN = 1'b0;
            end else begin
              // data space: combined program select, else data select
              for (int i = 0; i < 4; i++) begin
                if (csHot[i] && state_reg.mmap[i] && selEn[i]) begin
                  state_next.ext.port4Out[i] = 1'b0;
                end else if (csHot[i] && !state_reg.mmap[i]) begin
                  state_next.ext.dataSelN[i] = 1'b0;
                end
              end
              // combined reads use the fetch strobe, plain ones load
              if (req.kind == MMD_DWR) begin
                // writes always qualified by the store strobe
                state_next.ext.storeN      = 1'b0;
                state_next.ext.port0Data   = req.wdata;
                state_next.ext.port0DataEn = 1'b1;
              end else if (|(csHot & state_reg.mmap[3:0])) begin
                state_next.ext.fetchN = 1'b0;
              end else begin
                state_next.ext.loadN = 1'b0;
              end
            end
          end
        end
      end
      MMD_ST_STROBE: begin
        // strobes were released by the defaults above,
        // so the next request waits one cycle only
        state_next.st = MMD_ST_IDLE;
      end
      default: state_next.st = MMD_ST_IDLE;
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // clear everything, then load the power-up map
      state_reg                  <= '0;
      state_reg.p4fn             <= MMD_RST_P4FN;
      state_reg.mmap             <= MMD_RST_MMAP;
      state_reg.actl             <= MMD_RST_ACTL;
      state_reg.st               <= MMD_ST_IDLE;
      state_reg.lastTgt          <= MMD_TGT_NONE;
      // pins wake up as address lines and program selects
      state_reg.ext.port4AddrEn  <= 8'hff;
      state_reg.ext.port4Out     <= 8'h0f;
      // strobes and data selects idle high
      state_reg.ext.dataSelN     <= 4'hf;
      state_reg.ext.loadN        <= 1'b1;
      state_reg.ext.storeN       <= 1'b1;
      state_reg.ext.fetchN       <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// file: logic/mmd_pkg.sv
package mmd_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  MMD_IDX_P4FN   = 8'h92; // port4_pin_function
  localparam logic [7:0]  MMD_IDX_MMAP   = 8'hc6; // memory_map_control
  localparam logic [7:0]  MMD_IDX_ACTL   = 8'h9d; // address_ctrl
  localparam logic [7:0]  MMD_IDX_STAT   = 8'h9e; // decode status
  // reset values
  localparam logic [7:0]  MMD_RST_P4FN   = 8'h3f; // all address, all selects
  localparam logic [7:0]  MMD_RST_MMAP   = 8'h00;
  localparam logic [7:0]  MMD_RST_ACTL   = 8'h00;
  // field positions
  localparam int MMD_MAP_HI_BIT  = 7;  // internal_ram_map_sel_hi
  localparam int MMD_MAP_LO_BIT  = 6;  // internal_ram_map_sel_lo
  localparam int MMD_CAN_BIT     = 5;  // can_window_high
  localparam int MMD_STACK_BIT   = 2;  // stack_extend
  localparam int MMD_DEMUX_BIT   = 5;  // demultiplexed bus mode
  localparam int MMD_STAT_REFUSE = 7;  // sticky refused-access flag
  // memory windows, 23-bit addresses
  localparam logic [22:0] MMD_SRAM_LOW   = 23'h000000;
  localparam logic [22:0] MMD_SRAM_F000  = 23'h00f000;
  localparam logic [22:0] MMD_SRAM_HIGH  = 23'h400000;
  localparam logic [22:0] MMD_CAN_LOW    = 23'h00ee00;
  localparam logic [22:0] MMD_CAN_HIGH   = 23'h401000;
  localparam logic [22:0] MMD_SRAM_SIZE  = 23'h001000; // 4 kB
  localparam logic [22:0] MMD_CAN_SIZE   = 23'h000200; // 512 bytes
  localparam logic [22:0] MMD_STACK_SIZE = 23'h000400; // 1 kB
  // chip-select region widths in address bits per upper-address setting
  localparam logic [4:0]  MMD_CS_SH_000  = 5'd15; // 32 kB
  localparam logic [4:0]  MMD_CS_SH_100  = 5'd17; // 128 kB
  localparam logic [4:0]  MMD_CS_SH_101  = 5'd18; // 256 kB
  localparam logic [4:0]  MMD_CS_SH_110  = 5'd19; // 512 kB
  localparam logic [4:0]  MMD_CS_SH_111  = 5'd20; // 1 MB
  // access kinds from the core
  typedef enum logic [1:0] {
    MMD_FETCH = 2'h0, // instruction fetch
    MMD_CODE  = 2'h1, // code_read_move
    MMD_DRD   = 2'h2, // external_data_move read
    MMD_DWR   = 2'h3  // external_data_move write
  } mmd_kind_type;
  // where the last access went
  typedef enum logic [1:0] {
    MMD_TGT_EXT = 2'h0, MMD_TGT_SRAM = 2'h1,
    MMD_TGT_CAN = 2'h2, MMD_TGT_NONE = 2'h3
  } mmd_tgt_type;
  // external access sequencer, one-hot
  typedef enum logic [1:0] {
    MMD_ST_IDLE   = 2'b01,
    MMD_ST_STROBE = 2'b10
  } mmd_state_type;
  // access request from the core
  typedef struct packed {
    logic         valid;
    mmd_kind_type kind;
    logic         stack;   // extended stack access
    logic [22:0]  addr;
    logic [7:0]   wdata;
  } mmd_req_type;
  // external bus pins
  typedef struct packed {
    logic [7:0] port4Out;    // upper address lines and program selects
    logic [7:0] port4AddrEn; // per pin: 1 = memory function, 0 = I/O
    logic [3:0] dataSelN;    // data_chip_select, port 5 pins 7..4
    logic [7:0] port2Out;    // A15-A8
    logic [7:0] port0Addr;   // A7-A0 in multiplexed mode
    logic       port0AddrEn;
    logic [7:0] port1Out;    // A7-A0 in demultiplexed mode
    logic       port1AddrEn;
    logic [7:0] port0Data;   // write data
    logic       port0DataEn;
    logic       loadN;       // load_strobe_n
    logic       storeN;      // store_strobe_n
    logic       fetchN;      // program_fetch_strobe_n
  } mmd_ext_type;
  // on-chip memory selects
  typedef struct packed {
    logic        sramSel;
    logic        sramWr;
    logic [11:0] sramAddr;
    logic        canSel;
    logic        canWr;
    logic [8:0]  canAddr;
  } mmd_int_type;
endpackage

// file: tb/mmd_ext_flash.sv
`timescale 1ns/10ps
// behavioural flash on program select 0
module mmd_ext_flash (
  input  wire logic                 mclk,
  input  wire mmd_pkg::mmd_ext_type ext,
  output logic [7:0]                rdData,
  output logic [7:0]                lastWr
);
  import mmd_pkg::*;
  logic [7:0] mem [256];        // storage, low address bits only
  logic       sel;              // our select asserted
  logic [7:0] lo;               // low address from mux or demux pins
  assign sel = ext.port4AddrEn[0] & ~ext.port4Out[0];
  assign lo  = ext.port1AddrEn ? ext.port1Out : ext.port0Addr;
  initial rdData = 8'h5a;
  // write on store strobe, read data only under fetch strobe
  always @(posedge mclk) begin
    if (sel && !ext.storeN) begin
      mem[lo] <= ext.port0Data;
      lastWr  <= ext.port0Data;
    end
    // released bus shows a moving pattern, not the last value
    rdData <= (sel && !ext.fetchN) ? mem[lo] : ~rdData;
  end
endmodule

// file: tb/mmd_checker.sv
`timescale 1ns/10ps
module mmd_checker (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic [11:0]          paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 reqReady,
  input wire mmd_pkg::mmd_ext_type ext,
  input wire mmd_pkg::mmd_int_type intMem
);
  import mmd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic quiet; // all external strobes released
  assign quiet = ext.loadN & ext.storeN & ext.fetchN;
  // steps of one external access
  sequence strobeOn;
    !quiet;
  endsequence
  sequence gapThenFree;
    !reqReady ##1 (quiet && reqReady);
  endsequence
  sram_quiet_a: assert property (intMem.sramSel |-> quiet)
    else $error("strobe during sram access");
  can_quiet_a: assert property (intMem.canSel |-> quiet)
    else $error("strobe during message ram access");
  reset_map_a: assert property ($rose(resetn) |->
    ext.port4AddrEn == 8'hff && ext.port4Out[3:0] == 4'hf)
    else $error("pins not in reset map");
  ext_cycle_a: assert property (strobeOn |-> gapThenFree)
    else $error("external access timing wrong");
  fetch_space_a: assert property (!ext.fetchN |-> ext.dataSelN == 4'hf)
    else $error("data select during fetch strobe");
  load_space_a: assert property (!ext.loadN |->
    &(ext.port4Out[3:0] | ~ext.port4AddrEn[3:0]))
    else $error("program select during data read");
  store_only_a: assert property (!ext.storeN |->
    ext.port0DataEn && ext.loadN && ext.fetchN)
    else $error("bad write strobe");
  one_select_a: assert property (!quiet |->
    $onehot0(~ext.port4Out[3:0] & ext.port4AddrEn[3:0]))
    else $error("several program selects");
  apb_error_a: assert property (psel && penable && paddr[1:0] != 2'h0
    |-> pslverr && pready)
    else $error("misaligned access not refused");
endmodule
bind mmd_memory_map_decoder mmd_checker chk (.mclk, .resetn, .paddr,
  .psel, .penable, .pready, .pslverr, .reqReady, .ext, .intMem);

// file: tb/memory_map_decoder_tb.sv
`timescale 1ns/10ps
module memory_map_decoder_tb;
  import mmd_pkg::*;
  localparam logic [11:0] A_P4 = {2'h0, MMD_IDX_P4FN, 2'h0};
  localparam logic [11:0] A_MM = {2'h0, MMD_IDX_MMAP, 2'h0};
  localparam logic [11:0] A_AC = {2'h0, MMD_IDX_ACTL, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, MMD_IDX_STAT, 2'h0};
  logic        mclk = 1'b0, resetn = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, reqReady;
  mmd_req_type req = '0;
  logic [7:0]  port4Gpio = 8'h0, port1Gpio = 8'h0, rdData, lastWr;
  mmd_ext_type ext;
  mmd_int_type intMem;
  logic [7:0]  rnd = 8'h3d, lastWd;    // lfsr state, last write data
  logic [13:0] expQ [$];               // expected access results
  logic [13:0] obs;                    // observed access result
  logic [22:0] sb [3] = '{MMD_SRAM_F000, MMD_SRAM_LOW, MMD_SRAM_HIGH};
  logic [2:0]  up [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [3:0]  en [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  int          sh [5] = '{15, 17, 18, 19, 20};
  int          errors = 0, comparisons = 0, cyc = 0;
  logic [22:0] a;
  assign obs = intMem.sramSel ? {2'h1, intMem.sramAddr} :
               intMem.canSel ? {2'h2, 3'h0, intMem.canAddr} :
               {2'h0, ext.loadN, ext.storeN, ext.fetchN,
                ext.port4Out[3:0], ext.dataSelN, 1'b0};
  mmd_memory_map_decoder uut (.mclk, .resetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .req, .reqReady,
    .port4Gpio, .port1Gpio, .ext, .intMem);
  mmd_ext_flash flash (.mclk, .ext, .rdData, .lastWr);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected external result: strobes, program and data selects
  function automatic logic [13:0] xe(input logic [1:0] k,
    input logic [22:0] ad, input int w, input bit cb);
    logic [3:0] s;
    logic [2:0] st;
    logic       pg;
    s  = (ad >> w) < 4 ? ~(4'h1 << (ad >> w)) : 4'hf;
    pg = k < 2 || cb;
    st = k == 2'h3 ? 3'b101 : (pg ? 3'b110 : 3'b011);
    return {2'h0, st, pg ? s : 4'hf, pg ? 4'hf : s, 1'b0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // apb transfer; read data and error flag taken at the pready edge
  task automatic apb(input bit w, input logic [11:0] ad,
    input logic [7:0] d, input logic [7:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (!pready);
    chk(32'(pslverr), 32'(!(ad inside {A_P4, A_MM, A_AC, A_ST})));
    if (!w) chk(prdata, {24'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // core access; expected result queued at the taking edge
  task automatic acc(input logic [1:0] k, input logic [22:0] ad,
    input logic [13:0] e, input bit stk = 0, input bit tk = 1);
    rnd = lfsr(rnd);
    lastWd = rnd;
    port4Gpio <= rnd;
    port1Gpio <= ~rnd;
    req <= '{1'b1, mmd_kind_type'(k), stk, ad, rnd};
    do @(posedge mclk); while (!reqReady);
    if (tk) expQ.push_back(e);
    req.valid <= 1'b0;
    @(posedge mclk);
  endtask
  initial forever #25 mclk = ~mclk;
  // watchdog against hangs
  initial forever @(posedge mclk) if (++cyc == 3000) begin
    errors++;
    test_done();
  end
  // result monitor: any strobe or on-chip select pops one note, or is checked against zero when none is queued
  always @(posedge mclk) begin
    if (resetn && (intMem.sramSel | intMem.canSel |
        !(ext.loadN & ext.storeN & ext.fetchN))) begin
      if (expQ.size() == 0) chk(32'(obs), 32'h0);
      else chk(32'(obs), 32'(expQ.pop_front()));
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    acc(0, 23'h0, xe(0, 23'h0, 20, 0));
    chk(32'(ext.port4AddrEn), 32'hff);
    apb(0, A_P4, 8'h0, MMD_RST_P4FN);
    apb(0, A_MM, 8'h0, MMD_RST_MMAP);
    for (int i = 0; i < 5; i++) begin
      apb(1, A_P4, {2'h0, up[i], 3'h7}, 8'h0);
      @(posedge mclk);
      chk(32'(ext.port4AddrEn), {24'h0, en[i], 4'hf});
      a = 23'h3 << sh[i];
      acc(0, a, xe(0, a, sh[i], 0));
      acc(1, a - 1, xe(1, a - 1, sh[i], 0));
    end
    apb(1, A_P4, 8'h38, 8'h0);
    @(posedge mclk);
    chk(32'(ext.port4AddrEn), 32'hf0);
    chk(32'(ext.port4Out[3:0]), 32'(port4Gpio[3:0]));
    apb(1, A_P4, 8'h3f, 8'h0);
    apb(1, A_AC, 8'h20, 8'h0);
    acc(0, 23'h012345, xe(0, 23'h012345, 20, 0));
    chk({ext.port1AddrEn, ext.port1Out, ext.port2Out}, 32'h14523);
    apb(1, A_AC, 8'h0, 8'h0);
    for (int m = 0; m < 3; m++) for (int c = 0; c < 2; c++) begin
      apb(1, A_MM, {m[1:0], c[0], 5'h0}, 8'h0);
      acc(2, sb[m] + 23'hffe, {2'h1, 12'hffe});
      a = (c ? MMD_CAN_HIGH : MMD_CAN_LOW) + 23'h1ff;
      acc(3, a, {2'h2, 3'h0, 9'h1ff});
    end
    apb(1, A_MM, 8'hc0, 8'h0);
    acc(0, MMD_SRAM_HIGH + 23'h10, {2'h1, 12'h010});
    acc(2, MMD_SRAM_F000, xe(2, MMD_SRAM_F000, 20, 0));
    apb(1, A_AC, 8'h04, 8'h0);
    apb(0, A_AC, 8'h0, 8'h00);
    apb(1, A_MM, 8'h40, 8'h0);
    apb(1, A_AC, 8'h04, 8'h0);
    acc(2, 23'h10, 14'h0, 0, 0);
    acc(2, 23'h500, {2'h1, 12'h500});
    acc(3, 23'h3ff, {2'h1, 12'h3ff}, 1);
    apb(0, A_ST, 8'h0, 8'h81);
    apb(1, A_ST, 8'h80, 8'h0);
    apb(0, A_ST, 8'h0, 8'h01);
    apb(1, A_AC, 8'h0, 8'h0);
    apb(1, A_MM, 8'h01, 8'h0);
    acc(3, 23'h100, xe(3, 23'h100, 20, 1));
    @(posedge mclk);
    chk(32'(lastWr), 32'(lastWd));
    a = {15'h0, lastWd};
    acc(2, 23'h100, xe(2, 23'h100, 20, 1));
    @(posedge mclk);
    chk(32'(rdData), 32'(a[7:0]));
    apb(1, A_MM, 8'h0, 8'h0);
    acc(3, 23'h100, xe(3, 23'h100, 20, 0));
    acc(2, 23'h100, xe(2, 23'h100, 20, 0));
    apb(0, 12'h249, 8'h0, 8'h0);
    repeat (3) @(posedge mclk);
    chk(32'(expQ.size()), 32'h0);
    test_done();
  end
endmodule
